//--- verilog/ethernet_interrupt_logic.sv
// Ethernet event flags, enables, PHY interrupt registers and master interrupt
// Contract
// - Non-link flags set on their event regardless of any enable.
// - Master interrupt raised when an enabled flag is set and global enable set.
// - Enable register: bits 6,5,4,3,1,0; bits 7 and 2 read zero; reset zero.
// - Flag register mirrors enable layout; bits 7 and 2 zero; resets zero.
// - Packet flag read-only, set while pending count is nonzero.
// - DMA flag set on copy or checksum done, held until software clears.
// - Link flag read-only, set by PHY change, cleared by PHY flag read.
// - Transmit flag set when a transmit request ends.
// - Transmit-error flag set when a transmit error occurs.
// - Receive-error flag set when a packet is aborted.
// - DMA, transmit and error flags cleared by writing zero; writes never set.
// - PHY enable register: writable link-change enable at bit 4 and global enable at bit 1, rest zero.
// - PHY enable bit 1 is the global PHY enable; clear blocks PHY interrupts.
// - PHY status bit 13 shows transmitting.
// - PHY status bit 12 shows receiving.
// - PHY status bit 11 shows collision: transmit and receive in half duplex.
// - PHY status unimplemented and reserved bits read zero.
// - Link flag only set when both PHY enables are set.
// - PHY flag register read clears link, PHY global and PHY link flags.
// - PHY link flag records a change since the last PHY flag read.
module ethernet_interrupt_logic (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        sfrWrite,
  input  wire logic        sfrSelect,
  input  wire logic [7:0]  sfrWrData,
  output logic      [7:0]  sfrRdData,
  input  wire logic        globalNetIrqEnable,
  output logic             masterNetIrqFlag,
  input  wire logic [7:0]  pendingPacketCount,
  input  wire logic        dmaDoneEvt,
  input  wire logic        txDoneEvt,
  input  wire logic        txErrorEvt,
  input  wire logic        rxErrorEvt,
  input  wire logic        phyTransmittingPin,
  input  wire logic        phyReceivingPin,
  input  wire logic        phyLinkUpPin,
  input  wire logic        phyHalfDuplex,
  input  wire logic [4:0]  phyRegAddr,
  input  wire logic        phyRegRead,
  input  wire logic        phyRegWrite,
  input  wire logic [15:0] phyRegWrData,
  output logic      [15:0] phyRegRdData
);

  typedef struct packed {
    logic [7:0]  enable;
    logic        pktFlag;
    logic        phyLinkEn;
    logic        phyGlobalEn;
    logic        phyLinkFlag;
    logic        phyGlobalFlag;
    logic        linkFlag;
    logic        linkPrev;
    logic        linkPrevValid;
    logic        irq;
    logic [7:0]  sfrRd;
    logic [15:0] phyRd;
  } irq_state_t;

  irq_state_t  s_q;
  irq_state_t  s_d;
  logic [2:0]  syncOut;
  logic        txSync;
  logic        rxSync;
  logic        linkSync;
  logic        collisionNow;
  logic        linkChange;
  logic        phyFlagsRead;
  logic        phySetGlobal;
  logic [7:0]  setVec;
  logic [7:0]  clrVec;
  logic [7:0]  stickyQ;
  logic [7:0]  flagsNow;

  // Word returned for a PHY register read
  function automatic logic [15:0] phyRegValue(
    input logic [4:0] addr,
    input logic       tx,
    input logic       rx,
    input logic       col,
    input logic       lnk,
    input logic       linkEn,
    input logic       globalEn,
    input logic       linkFlg,
    input logic       globalFlg
  );
    logic [15:0] v;
    v = eth_irq_pkg::PHY_WORD_RESET;
    case (addr)
      eth_irq_pkg::PHY_STATUS_ADDR: begin
        v[eth_irq_pkg::STAT_TX_BIT]   = tx;
        v[eth_irq_pkg::STAT_RX_BIT]   = rx;
        v[eth_irq_pkg::STAT_COL_BIT]  = col;
        v[eth_irq_pkg::STAT_LINK_BIT] = lnk;
      end
      eth_irq_pkg::PHY_ENABLE_ADDR: begin
        v[eth_irq_pkg::PHY_EN_LINK_BIT]   = linkEn;
        v[eth_irq_pkg::PHY_EN_GLOBAL_BIT] = globalEn;
      end
      eth_irq_pkg::PHY_FLAGS_ADDR: begin
        v[eth_irq_pkg::PHY_FLG_LINK_BIT]   = linkFlg;
        v[eth_irq_pkg::PHY_FLG_GLOBAL_BIT] = globalFlg;
      end
      default: begin
        v = eth_irq_pkg::PHY_WORD_RESET;
      end
    endcase
    return v;
  endfunction : phyRegValue

  // Live PHY lines come from outside this clock
  bit_sync #(
    .WIDTH (eth_irq_pkg::SYNC_W)
  ) u_phy_sync (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .dataIn  ({phyLinkUpPin, phyReceivingPin, phyTransmittingPin}),
    .dataOut (syncOut)
  );

  assign txSync       = syncOut[0];
  assign rxSync       = syncOut[1];
  assign linkSync     = syncOut[2];
  assign collisionNow = txSync & rxSync & phyHalfDuplex;

  assign linkChange   = s_q.linkPrevValid & (linkSync != s_q.linkPrev);
  assign phyFlagsRead = phyRegRead && (phyRegAddr == eth_irq_pkg::PHY_FLAGS_ADDR);
  assign phySetGlobal = linkChange & s_q.phyLinkEn & s_q.phyGlobalEn;

  // Event sets, independent of enables
  always_comb begin
    setVec                         = 8'h00;
    setVec[eth_irq_pkg::DMA_BIT]   = dmaDoneEvt;
    setVec[eth_irq_pkg::TX_BIT]    = txDoneEvt | txErrorEvt;
    setVec[eth_irq_pkg::TXERR_BIT] = txErrorEvt;
    setVec[eth_irq_pkg::RXERR_BIT] = rxErrorEvt;
  end

  // Writing zero clears, writing one leaves the flag alone
  assign clrVec = (sfrWrite && sfrSelect == eth_irq_pkg::SEL_EVENT_FLAGS) ?
                  (~sfrWrData & eth_irq_pkg::CLEARABLE_MASK) : 8'h00;

  genvar g;
  generate
    for (g = 0; g < eth_irq_pkg::EVENT_W; g++) begin : g_flag
      if (eth_irq_pkg::CLEARABLE_MASK[g]) begin : g_sticky
        sticky_flag u_flag (
          .clk    (clk),
          .nrst   (nrst),
          .ce     (ce),
          .setEvt (setVec[g]),
          .clrReq (clrVec[g]),
          .flagQ  (stickyQ[g])
        );
      end else begin : g_none
        assign stickyQ[g] = 1'b0;
      end
    end
  endgenerate

  // Assembled flag register
  always_comb begin
    flagsNow                        = stickyQ;
    flagsNow[eth_irq_pkg::PKT_BIT]  = s_q.pktFlag;
    flagsNow[eth_irq_pkg::LINK_BIT] = s_q.linkFlag;
  end

  always_comb begin
    s_d = s_q;
    if (sfrWrite && sfrSelect == eth_irq_pkg::SEL_EVENT_ENABLE) begin
      s_d.enable = sfrWrData & eth_irq_pkg::EVENT_MASK;
    end
    s_d.pktFlag = (pendingPacketCount != 8'h00);
    if (phyRegWrite && phyRegAddr == eth_irq_pkg::PHY_ENABLE_ADDR) begin
      s_d.phyLinkEn   = phyRegWrData[eth_irq_pkg::PHY_EN_LINK_BIT];
      s_d.phyGlobalEn = phyRegWrData[eth_irq_pkg::PHY_EN_GLOBAL_BIT];
    end
    s_d.linkPrev      = linkSync;
    s_d.linkPrevValid = 1'b1;
    s_d.phyLinkFlag   = linkChange | (s_q.phyLinkFlag & ~phyFlagsRead);
    s_d.phyGlobalFlag = phySetGlobal | (s_q.phyGlobalFlag & ~phyFlagsRead);
    s_d.linkFlag      = phySetGlobal | (s_q.linkFlag & ~phyFlagsRead);
    s_d.irq = globalNetIrqEnable & (|(flagsNow & s_q.enable));
    s_d.sfrRd = (sfrSelect == eth_irq_pkg::SEL_EVENT_FLAGS) ? flagsNow : s_q.enable;
    if (phyRegRead) begin
      s_d.phyRd = phyRegValue(phyRegAddr, txSync, rxSync, collisionNow, linkSync,
                              s_q.phyLinkEn, s_q.phyGlobalEn,
                              s_q.phyLinkFlag, s_q.phyGlobalFlag);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q        <= '0;
      s_q.enable <= eth_irq_pkg::EVENT_ENABLE_RESET;
      s_q.sfrRd  <= eth_irq_pkg::EVENT_FLAGS_RESET;
      s_q.phyRd  <= eth_irq_pkg::PHY_WORD_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sfrRdData        = s_q.sfrRd;
  assign masterNetIrqFlag = s_q.irq;
  assign phyRegRdData     = s_q.phyRd;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_irq_gating: assert property (
    ce |=> masterNetIrqFlag == $past(globalNetIrqEnable && (|(flagsNow & s_q.enable))))
    else $error("Master interrupt does not follow enabled flags");

  chk_enable_layout: assert property (
    ce && sfrWrite && sfrSelect == eth_irq_pkg::SEL_EVENT_ENABLE
    |=> s_q.enable == ($past(sfrWrData) & 8'h7B))
    else $error("Enable register layout wrong");

  chk_unused_zero: assert property (
    flagsNow[7] == 1'b0 && flagsNow[2] == 1'b0 && s_q.enable[7] == 1'b0 && s_q.enable[2] == 1'b0)
    else $error("Unimplemented event bit set");

  chk_pkt_pending: assert property (
    ce |=> flagsNow[eth_irq_pkg::PKT_BIT] == ($past(pendingPacketCount) != 8'h00))
    else $error("Packet flag does not track pending count");

  chk_dma_poll: assert property (
    ce && dmaDoneEvt && !s_q.enable[eth_irq_pkg::DMA_BIT] |=> flagsNow[eth_irq_pkg::DMA_BIT])
    else $error("Disabled DMA event not flagged");

  chk_txerr_sets_tx: assert property (
    ce && txErrorEvt |=> flagsNow[eth_irq_pkg::TX_BIT] && flagsNow[eth_irq_pkg::TXERR_BIT])
    else $error("Transmit error did not flag both bits");

  chk_write_no_set: assert property (
    ce && sfrWrite && sfrSelect == eth_irq_pkg::SEL_EVENT_FLAGS
    && !rxErrorEvt && !flagsNow[eth_irq_pkg::RXERR_BIT] |=> !flagsNow[eth_irq_pkg::RXERR_BIT])
    else $error("Software write set a flag");

  chk_write_clear: assert property (
    ce && sfrWrite && sfrSelect == eth_irq_pkg::SEL_EVENT_FLAGS
    && !sfrWrData[eth_irq_pkg::DMA_BIT] && !dmaDoneEvt |=> !flagsNow[eth_irq_pkg::DMA_BIT])
    else $error("Flag not cleared by write of zero");

  chk_link_gated: assert property (
    ce && !s_q.linkFlag && !(s_q.phyLinkEn && s_q.phyGlobalEn) |=> !s_q.linkFlag)
    else $error("Link flag set with PHY interrupts disabled");

  chk_flag_read_clear: assert property (
    ce && phyFlagsRead && !linkChange |=> !s_q.linkFlag && !s_q.phyLinkFlag && !s_q.phyGlobalFlag)
    else $error("PHY flag read did not clear link flags");

  chk_link_detect: assert property (
    ce && s_q.linkPrevValid && $changed(linkSync) |=> s_q.phyLinkFlag)
    else $error("Link change not recorded");

  chk_status_read: assert property (
    ce && phyRegRead && phyRegAddr == eth_irq_pkg::PHY_STATUS_ADDR
    |=> phyRegRdData[13:10] == $past({txSync, rxSync, txSync & rxSync & phyHalfDuplex, linkSync}))
    else $error("PHY status word wrong");

  chk_reserved_zero: assert property (
    (phyRegRdData & ~eth_irq_pkg::PHY_DEFINED_MASK) == 16'h0000)
    else $error("Reserved PHY bit read nonzero");

  chk_txerr_flag: assert property (
    ce && txErrorEvt |=> flagsNow[eth_irq_pkg::TXERR_BIT])
    else $error("Transmit error not flagged");

  chk_rxerr_flag: assert property (
    ce && rxErrorEvt |=> flagsNow[eth_irq_pkg::RXERR_BIT])
    else $error("Receive error not flagged");

  chk_dma_hold: assert property (
    ce && flagsNow[eth_irq_pkg::DMA_BIT] && !clrVec[eth_irq_pkg::DMA_BIT] |=> flagsNow[eth_irq_pkg::DMA_BIT])
    else $error("DMA flag dropped without a clear");

  chk_link_sticky: assert property (
    ce && s_q.linkFlag && !phyFlagsRead |=> s_q.linkFlag)
    else $error("Link flag cleared without a PHY flag read");

  chk_phy_en_write: assert property (
    ce && phyRegWrite && phyRegAddr == eth_irq_pkg::PHY_ENABLE_ADDR
    |=> s_q.phyLinkEn == $past(phyRegWrData[eth_irq_pkg::PHY_EN_LINK_BIT]))
    else $error("PHY link enable not written");

  chk_global_blocks: assert property (
    ce && !s_q.phyGlobalEn && !s_q.phyGlobalFlag |=> !s_q.phyGlobalFlag)
    else $error("PHY global flag set while PHY interrupts disabled");

  chk_link_status: assert property (
    ce && phyRegRead && phyRegAddr == eth_irq_pkg::PHY_STATUS_ADDR
    |=> phyRegRdData[eth_irq_pkg::STAT_LINK_BIT] == $past(linkSync))
    else $error("PHY link status bit wrong");

  cov_irq_raise: cover property (ce && !masterNetIrqFlag ##1 masterNetIrqFlag);
  cov_link_flag: cover property (ce && !s_q.linkFlag ##1 s_q.linkFlag);
  cov_flag_read_clear: cover property (s_q.linkFlag && phyFlagsRead && ce ##1 !s_q.linkFlag);
  cov_set_clear_same: cover property (ce && dmaDoneEvt && clrVec[eth_irq_pkg::DMA_BIT]);

endmodule : ethernet_interrupt_logic

//--- verilog/eth_irq_pkg.sv
// Constants shared by the Ethernet interrupt logic
package eth_irq_pkg;

  // Event enable / flag register layout
  localparam int          EVENT_W            = 8;
  localparam int          PKT_BIT            = 6;
  localparam int          DMA_BIT            = 5;
  localparam int          LINK_BIT           = 4;
  localparam int          TX_BIT             = 3;
  localparam int          TXERR_BIT          = 1;
  localparam int          RXERR_BIT          = 0;
  localparam logic [7:0]  EVENT_MASK         = 8'h7B;
  localparam logic [7:0]  CLEARABLE_MASK     = 8'h2B;
  localparam logic [7:0]  EVENT_ENABLE_RESET = 8'h00;
  localparam logic [7:0]  EVENT_FLAGS_RESET  = 8'h00;

  // Processor register select
  localparam logic        SEL_EVENT_ENABLE   = 1'b0;
  localparam logic        SEL_EVENT_FLAGS    = 1'b1;

  // PHY register addresses
  localparam int          PHY_ADDR_W         = 5;
  localparam logic [4:0]  PHY_STATUS_ADDR    = 5'h11;
  localparam logic [4:0]  PHY_ENABLE_ADDR    = 5'h12;
  localparam logic [4:0]  PHY_FLAGS_ADDR     = 5'h13;

  // PHY register fields
  localparam int          PHY_W              = 16;
  localparam int          STAT_TX_BIT        = 13;
  localparam int          STAT_RX_BIT        = 12;
  localparam int          STAT_COL_BIT       = 11;
  localparam int          STAT_LINK_BIT      = 10;
  localparam int          PHY_EN_LINK_BIT    = 4;
  localparam int          PHY_EN_GLOBAL_BIT  = 1;
  localparam int          PHY_FLG_LINK_BIT   = 4;
  localparam int          PHY_FLG_GLOBAL_BIT = 2;
  localparam logic [15:0] PHY_DEFINED_MASK   = 16'h3C16;
  localparam logic [15:0] PHY_WORD_RESET     = 16'h0000;

  // Synchroniser width for the live PHY lines
  localparam int          SYNC_W             = 3;

endpackage : eth_irq_pkg

//--- verilog/bit_sync.sv
// Two-stage synchroniser for PHY status lines
module bit_sync #(
  parameter int WIDTH = eth_irq_pkg::SYNC_W
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] dataIn,
  output logic      [WIDTH-1:0] dataOut
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.first  = dataIn;
    s_d.second = s_q.first;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign dataOut = s_q.second;

endmodule : bit_sync

//--- verilog/sticky_flag.sv
// Sticky event flag, set wins over clear
module sticky_flag (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic setEvt,
  input  wire logic clrReq,
  output logic      flagQ
);

  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t s_q;
  flag_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.flag = setEvt | (s_q.flag & ~clrReq);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign flagQ = s_q.flag;

  chk_set_beats_clear: assert property (@(posedge clk) disable iff (!nrst)
    ce && setEvt |=> flagQ) else $error("Flag lost its set event");
  chk_clear_holds: assert property (@(posedge clk) disable iff (!nrst)
    ce && clrReq && !setEvt |=> !flagQ) else $error("Flag not cleared");

endmodule : sticky_flag

//--- sim/host_model.sv
// Processor side: global net interrupt enable and interrupt latch
module host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic enableReq,
  input  wire logic clrSeen,
  input  wire logic irqLine,
  output logic      globalEnable,
  output logic      irqSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      globalEnable <= 1'b0;
      irqSeen      <= 1'b0;
    end else begin
      globalEnable <= enableReq;
      irqSeen      <= clrSeen ? 1'b0 : (irqSeen | irqLine);
    end
  end
endmodule : host_model

//--- sim/ethernet_interrupt_logic_tb.sv
// Register level testbench for the Ethernet interrupt logic
module ethernet_interrupt_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, sfrWrite, sfrSelect, masterNetIrqFlag, dmaDoneEvt, txDoneEvt;
  logic        txErrorEvt, rxErrorEvt, phyTx, phyRx, phyLink, phyHalfDuplex, phyRegRead;
  logic        phyRegWrite, enableReq, clrSeen, globalEn, irqSeen;
  logic [7:0]  sfrWrData, sfrRdData, pendingPacketCount;
  logic [4:0]  phyRegAddr;
  logic [15:0] phyRegWrData, phyRegRdData;
  int          num_errors, comparisons;

  ethernet_interrupt_logic dut (.clk(clk), .nrst(nrst), .ce(1'b1), .sfrWrite(sfrWrite),
    .sfrSelect(sfrSelect), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .globalNetIrqEnable(globalEn), .masterNetIrqFlag(masterNetIrqFlag),
    .pendingPacketCount(pendingPacketCount), .dmaDoneEvt(dmaDoneEvt), .txDoneEvt(txDoneEvt),
    .txErrorEvt(txErrorEvt), .rxErrorEvt(rxErrorEvt), .phyTransmittingPin(phyTx),
    .phyReceivingPin(phyRx), .phyLinkUpPin(phyLink), .phyHalfDuplex(phyHalfDuplex),
    .phyRegAddr(phyRegAddr), .phyRegRead(phyRegRead), .phyRegWrite(phyRegWrite),
    .phyRegWrData(phyRegWrData), .phyRegRdData(phyRegRdData));
  host_model host (.clk(clk), .nrst(nrst), .enableReq(enableReq), .clrSeen(clrSeen),
    .irqLine(masterNetIrqFlag), .globalEnable(globalEn), .irqSeen(irqSeen));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic sfr_wr(input logic sel, input logic [7:0] data);
    @(negedge clk);
    sfrSelect = sel;
    sfrWrData = data;
    sfrWrite  = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic sel, output logic [15:0] val);
    @(negedge clk);
    sfrSelect = sel;
    repeat (2) @(negedge clk);
    val = {8'h00, sfrRdData};
  endtask : sfr_rd

  task automatic phy_acc(input logic wr, input logic [4:0] addr, input logic [15:0] data,
                         output logic [15:0] val);
    @(negedge clk);
    phyRegAddr   = addr;
    phyRegWrData = data;
    phyRegRead   = ~wr;
    phyRegWrite  = wr;
    @(negedge clk);
    phyRegRead  = 1'b0;
    phyRegWrite = 1'b0;
    @(negedge clk);
    val = phyRegRdData;
  endtask : phy_acc

  task automatic pulse(input logic [3:0] evts);
    @(negedge clk);
    {dmaDoneEvt, txDoneEvt, txErrorEvt, rxErrorEvt} = evts;
    @(negedge clk);
    {dmaDoneEvt, txDoneEvt, txErrorEvt, rxErrorEvt} = 4'h0;
    repeat (2) @(negedge clk);
  endtask : pulse

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    logic [15:0] v;
    num_errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    {sfrWrite, sfrSelect, sfrWrData, pendingPacketCount} = '0;
    {dmaDoneEvt, txDoneEvt, txErrorEvt, rxErrorEvt, phyTx, phyRx, phyLink} = '0;
    {phyHalfDuplex, phyRegAddr, phyRegRead, phyRegWrite, phyRegWrData} = '0;
    {enableReq, clrSeen} = 2'b00;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    sfr_rd(eth_irq_pkg::SEL_EVENT_ENABLE, v); check(v, 16'h0000);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    phy_acc(1'b0, eth_irq_pkg::PHY_ENABLE_ADDR, 16'h0000, v); check(v, 16'h0000);
    sfr_wr(eth_irq_pkg::SEL_EVENT_ENABLE, 8'hFF);
    sfr_rd(eth_irq_pkg::SEL_EVENT_ENABLE, v); check(v, 16'h007B);
    sfr_wr(eth_irq_pkg::SEL_EVENT_ENABLE, 8'h00);
    enableReq = 1'b1;
    // Events land with every event enable clear
    pulse(4'h2);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h000A);
    check({15'h0, masterNetIrqFlag}, 16'h0000);
    sfr_wr(eth_irq_pkg::SEL_EVENT_ENABLE, 8'h7B);
    wait_n(2);
    check({15'h0, masterNetIrqFlag}, 16'h0001);
    check({15'h0, irqSeen}, 16'h0001);
    sfr_wr(eth_irq_pkg::SEL_EVENT_FLAGS, 8'hFF);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h000A);
    sfr_wr(eth_irq_pkg::SEL_EVENT_FLAGS, 8'h00);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    check({15'h0, masterNetIrqFlag}, 16'h0000);
    clrSeen = 1'b1;
    wait_n(1);
    clrSeen = 1'b0;
    wait_n(2);
    check({15'h0, irqSeen}, 16'h0000);
    enableReq = 1'b0;
    pulse(4'h9);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0021);
    check({15'h0, masterNetIrqFlag}, 16'h0000);
    pulse(4'h4);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0029);
    sfr_wr(eth_irq_pkg::SEL_EVENT_FLAGS, 8'h00);
    enableReq = 1'b1;
    pendingPacketCount = 8'h03;
    sfr_wr(eth_irq_pkg::SEL_EVENT_FLAGS, 8'h00);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0040);
    check({15'h0, masterNetIrqFlag}, 16'h0001);
    pendingPacketCount = 8'h00;
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    // Live status lines, link rising with PHY enables clear
    {phyTx, phyRx, phyHalfDuplex, phyLink} = 4'hF;
    wait_n(6);
    phy_acc(1'b0, eth_irq_pkg::PHY_STATUS_ADDR, 16'h0000, v); check(v, 16'h3C00);
    phyHalfDuplex = 1'b0;
    phy_acc(1'b0, eth_irq_pkg::PHY_STATUS_ADDR, 16'h0000, v); check(v, 16'h3400);
    {phyTx, phyRx} = 2'b00;
    wait_n(6);
    phy_acc(1'b0, eth_irq_pkg::PHY_STATUS_ADDR, 16'h0000, v); check(v, 16'h0400);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    phy_acc(1'b0, eth_irq_pkg::PHY_FLAGS_ADDR, 16'h0000, v); check(v, 16'h0010);
    phy_acc(1'b0, eth_irq_pkg::PHY_FLAGS_ADDR, 16'h0000, v); check(v, 16'h0000);
    phy_acc(1'b1, eth_irq_pkg::PHY_ENABLE_ADDR, 16'hFFFF, v);
    phy_acc(1'b0, eth_irq_pkg::PHY_ENABLE_ADDR, 16'h0000, v); check(v, 16'h0012);
    phy_acc(1'b0, 5'h1F, 16'h0000, v); check(v, 16'h0000);
    // Link drops with both PHY enables set
    phyLink = 1'b0;
    wait_n(6);
    phy_acc(1'b0, eth_irq_pkg::PHY_STATUS_ADDR, 16'h0000, v); check(v, 16'h0000);
    sfr_wr(eth_irq_pkg::SEL_EVENT_FLAGS, 8'h00);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0010);
    check({15'h0, masterNetIrqFlag}, 16'h0001);
    phy_acc(1'b0, eth_irq_pkg::PHY_FLAGS_ADDR, 16'h0000, v); check(v, 16'h0014);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    phy_acc(1'b1, eth_irq_pkg::PHY_ENABLE_ADDR, 16'h0010, v);
    phyLink = 1'b1;
    wait_n(6);
    sfr_rd(eth_irq_pkg::SEL_EVENT_FLAGS, v); check(v, 16'h0000);
    close_out();
  end
endmodule : ethernet_interrupt_logic_tb
